// *** hw/ebtp_top.sv ***
// eight-bit timer/counter with shared prescaler and watchdog counter,
// registers on an apb slave, one level interrupt.
// assumes: apb master on i_clk_sys, external count pin asynchronous,
// i_sleep driven by core logic on the same clock.
//
// Contract
// RULE1 - one prescaler, timer or watchdog, never both
// RULE2 - assign bit zero gives prescaler to timer
// RULE3 - select field picks ratio 1:2 to 1:256
// RULE4 - timer counts 1:1 only when prescaler on watchdog
// RULE5 - prescaler count never read nor loaded
// RULE6 - count write clears prescaler when on timer
// RULE7 - watchdog clear clears both when on watchdog
// RULE8 - overflow event on wrap from FF to 00
// RULE9 - flag set on every wrap, enable ignored
// RULE10 - only software clears the overflow flag
// RULE11 - interrupt needs both flag and enable
// RULE12 - timer frozen during sleep
// RULE13 - counter mode sampled on Q2 and Q4
// RULE14 - timer mode counts prescaled instruction ticks
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "ebtp_map.svh"
module ebtp_top (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_sleep,
    input  wire logic        i_ext_count_input,
    output logic             o_irq,
    output logic             o_wdt_timeout
);

    // ****************************************
    // declarations
    // ****************************************
    ebtp_pkg::ebtp_apb_req_t req;
    ebtp_pkg::ebtp_option_t  option_q;
    ebtp_pkg::ebtp_phase_t   phase_q;
    ebtp_pkg::ebtp_phase_t   phase_d;
    logic [7:0]              count_q;
    logic                    ovf_flag_q;
    logic                    ovf_en_q;
    logic                    wdt_flag_q;
    logic                    wdt_mask_q;
    logic                    wd_en_q;
    logic [7:0]              wd_cnt_q;
    logic                    pready_q;
    logic                    pslverr_q;
    logic [31:0]             prdata_q;
    logic                    irq_q, wdt_to_q;
    logic                    samp_q2_q, samp_q4_q;
    logic                    wr_acc, wr_count, wd_clear;
    logic                    instr_tick, ext_level, ext_rise;
    logic                    psc_tick, psc_clear, psc_pulse;
    logic                    psc_level, cnt_src, tmr_inc;
    logic                    ovf_event, wd_tick, wd_event;
    logic                    ovf_clr, wdt_clr;
    logic                    mapped;
    logic [31:0]             rd_mux;

    // address compare used by every register decoder
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction : hit

    // gather the bus pins into one carrier
    assign req.sel    = i_psel;
    assign req.enable = i_penable;
    assign req.write  = i_pwrite;
    assign req.addr   = i_paddr;
    assign req.wdata  = i_pwdata;

    // ****************************************
    // apb handshake
    // ****************************************
    // one wait state: pready rises in the second access cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= req.sel & req.enable & ~pready_q;
        end
    end

    // a write takes effect only at the completing edge
    assign wr_acc   = req.sel & req.enable & pready_q & req.write & mapped;
    assign wr_count = wr_acc & hit(req.addr, `EBTP_OFF_COUNT);
    assign wd_clear = wr_acc & hit(req.addr, `EBTP_OFF_WDOG)
                    & req.wdata[`EBTP_WD_CLR_BIT];

    // unmapped addresses answer with an error and zero data
    assign mapped = (req.addr <= `EBTP_OFF_WDOG) & (req.addr[1:0] == 2'h0);

    // ****************************************
    // read mux
    // ****************************************
    // prescaler count has no read path at all
    always_comb begin
        rd_mux = 32'h0000_0000; // RULE5
        if (hit(req.addr, `EBTP_OFF_COUNT)) begin
            rd_mux[7:0] = count_q;
        end else if (hit(req.addr, `EBTP_OFF_OPTION)) begin
            rd_mux[7:0] = option_q;
        end else if (hit(req.addr, `EBTP_OFF_INTCTL)) begin
            rd_mux[`EBTP_INT_FLAG_BIT] = ovf_flag_q;
            rd_mux[`EBTP_INT_EN_BIT]   = ovf_en_q;
        end else if (hit(req.addr, `EBTP_OFF_STATUS)) begin
            rd_mux[`EBTP_ST_OVF_BIT] = ovf_flag_q;
            rd_mux[`EBTP_ST_WDT_BIT] = wdt_flag_q;
        end else if (hit(req.addr, `EBTP_OFF_MASK)) begin
            rd_mux[`EBTP_ST_OVF_BIT] = ovf_en_q;
            rd_mux[`EBTP_ST_WDT_BIT] = wdt_mask_q;
        end else if (hit(req.addr, `EBTP_OFF_WDOG)) begin
            rd_mux[`EBTP_WD_EN_BIT] = wd_en_q;
            rd_mux[`EBTP_WD_CNT_LSB +: 8] = wd_cnt_q;
        end
    end

    // read data and error are held with pready
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (req.sel & req.enable & ~pready_q) begin
            prdata_q  <= rd_mux;
            pslverr_q <= ~mapped;
        end else begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
    end

    // ****************************************
    // option register
    // ****************************************
    // select and assign steer the prescaler routing below
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            option_q <= `EBTP_RST_OPTION;
        end else if (wr_acc & hit(req.addr, `EBTP_OFF_OPTION)) begin
            option_q <= req.wdata[7:0];
        end
    end

    // ****************************************
    // instruction clock phases
    // ****************************************
    // four system clocks make one instruction cycle
    always_comb begin
        case (phase_q)
            ebtp_pkg::EBTP_Q1: phase_d = ebtp_pkg::EBTP_Q2;
            ebtp_pkg::EBTP_Q2: phase_d = ebtp_pkg::EBTP_Q3;
            ebtp_pkg::EBTP_Q3: phase_d = ebtp_pkg::EBTP_Q4;
            ebtp_pkg::EBTP_Q4: phase_d = ebtp_pkg::EBTP_Q1;
            default:           phase_d = ebtp_pkg::EBTP_Q1;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            phase_q <= ebtp_pkg::EBTP_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign instr_tick = (phase_q == ebtp_pkg::EBTP_Q4);

    // ****************************************
    // external count pin
    // ****************************************
    ebtp_pin_sync u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_pin     (i_ext_count_input),
        .i_invert  (option_q.edge_fall),
        .o_level   (ext_level),
        .o_rise    (ext_rise)
    );

    // ****************************************
    // shared prescaler routing
    // ****************************************
    // the prescaler follows exactly one owner at a time
    always_comb begin
        if (option_q.assign_wdt) begin // RULE1 RULE2
            psc_tick  = instr_tick;
            psc_clear = wd_clear; // RULE7
        end else begin
            psc_tick  = ~i_sleep & (option_q.ext_mode ? ext_rise : instr_tick);
            psc_clear = wr_count; // RULE6
        end
    end

    ebtp_presc u_presc (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_tick    (psc_tick),
        .i_clear   (psc_clear),
        .i_sel     (option_q.sel), // RULE3
        .o_pulse   (psc_pulse),
        .o_level   (psc_level)
    );

    // ****************************************
    // counter mode sampling
    // ****************************************
    // source seen by the sampler: divided, or the bare pin
    assign cnt_src = option_q.assign_wdt ? ext_level : psc_level; // RULE4

    // sample at Q2, confirm at Q4: an edge is counted once per
    // instruction cycle at most, so fast pins are undercounted
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            samp_q2_q <= 1'b0;
            samp_q4_q <= 1'b0;
        end else if (phase_q == ebtp_pkg::EBTP_Q2) begin
            samp_q2_q <= cnt_src; // RULE13
        end else if (phase_q == ebtp_pkg::EBTP_Q4) begin
            samp_q4_q <= samp_q2_q; // RULE13
        end
    end

    // ****************************************
    // count register
    // ****************************************
    // increment source per mode; frozen while asleep
    always_comb begin
        if (i_sleep) begin
            tmr_inc = 1'b0; // RULE12
        end else if (option_q.ext_mode) begin
            tmr_inc = instr_tick & samp_q2_q & ~samp_q4_q; // RULE13
        end else if (option_q.assign_wdt) begin
            tmr_inc = instr_tick; // RULE4
        end else begin
            tmr_inc = psc_pulse; // RULE14
        end
    end

    // a software write beats a same-cycle increment
    assign ovf_event = tmr_inc & ~wr_count & (count_q == `EBTP_COUNT_MAX); // RULE8

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            count_q <= `EBTP_RST_COUNT;
        end else if (wr_count) begin
            count_q <= req.wdata[7:0];
        end else if (tmr_inc) begin
            count_q <= count_q + 8'h01; // RULE8
        end
    end

    // ****************************************
    // watchdog counter
    // ****************************************
    // keeps running in sleep; divided only when it owns the prescaler
    assign wd_tick  = wd_en_q & (option_q.assign_wdt ? psc_pulse : instr_tick);
    assign wd_event = wd_tick & ~wd_clear & (wd_cnt_q == `EBTP_COUNT_MAX);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            wd_en_q <= 1'(`EBTP_RST_WDOG >> `EBTP_WD_EN_BIT);
        end else if (wr_acc & hit(req.addr, `EBTP_OFF_WDOG)) begin
            wd_en_q <= req.wdata[`EBTP_WD_EN_BIT];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            wd_cnt_q <= 8'h00;
        end else if (wd_clear) begin
            wd_cnt_q <= 8'h00; // RULE7
        end else if (wd_tick) begin
            wd_cnt_q <= wd_cnt_q + 8'h01;
        end
    end

    // ****************************************
    // status, mask and interrupt
    // ****************************************
    // write one clears; both views of the flag share the flop
    assign ovf_clr = wr_acc & ((hit(req.addr, `EBTP_OFF_STATUS)
                   & req.wdata[`EBTP_ST_OVF_BIT])
                   | (hit(req.addr, `EBTP_OFF_INTCTL)
                   & req.wdata[`EBTP_INT_FLAG_BIT]));
    assign wdt_clr = wr_acc & hit(req.addr, `EBTP_OFF_STATUS)
                   & req.wdata[`EBTP_ST_WDT_BIT];

    // set wins over clear so no wrap is lost
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ovf_flag_q <= 1'b0;
            wdt_flag_q <= 1'b0;
        end else begin
            ovf_flag_q <= ovf_event | (ovf_flag_q & ~ovf_clr); // RULE9 RULE10
            wdt_flag_q <= wd_event | (wdt_flag_q & ~wdt_clr);
        end
    end

    // enable reachable from the control and the mask view
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ovf_en_q   <= 1'(`EBTP_RST_INTCTL >> `EBTP_INT_EN_BIT);
            wdt_mask_q <= 1'b0;
        end else if (wr_acc & hit(req.addr, `EBTP_OFF_INTCTL)) begin
            ovf_en_q <= req.wdata[`EBTP_INT_EN_BIT];
        end else if (wr_acc & hit(req.addr, `EBTP_OFF_MASK)) begin
            ovf_en_q   <= req.wdata[`EBTP_ST_OVF_BIT];
            wdt_mask_q <= req.wdata[`EBTP_ST_WDT_BIT];
        end
    end

    // registered so the output comes straight from a flop
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            irq_q    <= 1'b0;
            wdt_to_q <= 1'b0;
        end else begin
            irq_q    <= (ovf_flag_q & ovf_en_q) | (wdt_flag_q & wdt_mask_q); // RULE11
            wdt_to_q <= wd_event;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_prdata      = prdata_q;
    assign o_pready      = pready_q;
    assign o_pslverr     = pslverr_q;
    assign o_irq         = irq_q;
    assign o_wdt_timeout = wdt_to_q;

endmodule : ebtp_top

// *** hw/ebtp_map.svh ***
// register map, field positions, reset values and timing counts
// of the eight-bit timer with shared prescaler.
// assumes: included by bare name from design files.
`ifndef EBTP_MAP_SVH
`define EBTP_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define EBTP_OFF_COUNT      8'h00
`define EBTP_OFF_OPTION     8'h04
`define EBTP_OFF_INTCTL     8'h08
`define EBTP_OFF_STATUS     8'h0C
`define EBTP_OFF_MASK       8'h10
`define EBTP_OFF_WDOG       8'h14

// ****************************************
// field positions
// ****************************************
`define EBTP_OPT_SEL_LSB    0
`define EBTP_OPT_ASSIGN_BIT 3
`define EBTP_OPT_EDGE_BIT   4
`define EBTP_OPT_EXT_BIT    5
`define EBTP_INT_FLAG_BIT   2
`define EBTP_INT_EN_BIT     5
`define EBTP_ST_OVF_BIT     0
`define EBTP_ST_WDT_BIT     1
`define EBTP_WD_CLR_BIT     0
`define EBTP_WD_EN_BIT      1
`define EBTP_WD_CNT_LSB     8

// ****************************************
// reset values
// ****************************************
`define EBTP_RST_COUNT      8'h00
`define EBTP_RST_OPTION     8'h08
`define EBTP_RST_INTCTL     8'h00
`define EBTP_RST_WDOG       8'h00

// ****************************************
// timing
// ****************************************
`define EBTP_CLK_NS         10
`define EBTP_INSTR_NS       40
`define EBTP_PHASES         (`EBTP_INSTR_NS / `EBTP_CLK_NS)
`define EBTP_COUNT_MAX      8'hFF

`endif

// *** hw/ebtp_pkg.sv ***
// types shared by the eight-bit timer files.
// assumes: ebtp_map.svh holds every number.
package ebtp_pkg;

    // ****************************************
    // option register layout
    // ****************************************
    typedef struct packed {
        logic [1:0] spare;
        logic       ext_mode;    // 1: count the external pin
        logic       edge_fall;   // 1: count falling edges
        logic       assign_wdt;  // prescaler_assign
        logic [2:0] sel;         // prescale_select
    } ebtp_option_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ebtp_apb_req_t;

    // instruction clock phases, one system clock each
    typedef enum logic [1:0] {
        EBTP_Q1 = 2'b00,
        EBTP_Q2 = 2'b01,
        EBTP_Q3 = 2'b10,
        EBTP_Q4 = 2'b11
    } ebtp_phase_t;

endpackage : ebtp_pkg

// *** hw/ebtp_pin_sync.sv ***
// two-flop synchroniser with edge select for the external count pin.
// assumes: pin is asynchronous to i_clk_sys.
`timescale 1ns/1ps
module ebtp_pin_sync (
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    input  wire logic i_pin,
    input  wire logic i_invert,
    output logic      o_level,
    output logic      o_rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // ****************************************
    // synchroniser
    // ****************************************
    // first flop feeds only the second
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
        end
    end

    // edge history taken after the edge select
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= o_level;
        end
    end

    // falling edges become rising ones by inversion
    assign o_level = sync_q ^ i_invert;
    assign o_rise  = o_level & ~prev_q;

endmodule : ebtp_pin_sync

// *** hw/ebtp_presc.sv ***
// shared prescaler: divides an input tick by 2 up to 256.
// assumes: clear and tick come from logic on i_clk_sys.
`timescale 1ns/1ps
module ebtp_presc (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire logic       i_tick,
    input  wire logic       i_clear,
    input  wire logic [2:0] i_sel,
    output logic            o_pulse,
    output logic            o_level
);
    logic [7:0] cnt_q;

    // low bits that must all be set for a carry out
    function automatic logic [7:0] span(input logic [2:0] sel);
        logic [7:0] top;
        top = 8'h02 << sel;
        return top - 8'h01;
    endfunction : span

    // ****************************************
    // counter, hidden from software
    // ****************************************
    // clear wins so a restart never leaks a stale carry
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            cnt_q <= 8'h00;
        end else if (i_clear) begin
            cnt_q <= 8'h00;
        end else if (i_tick) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // ratio doubles with each select step
    assign o_pulse = i_tick & ~i_clear & ((cnt_q & span(i_sel)) == span(i_sel));
    assign o_level = cnt_q[i_sel];

endmodule : ebtp_presc

// *** hw/ebtp_top_end.sv ***
// spare slot, holds no logic; the block's top is ebtp_top

// *** testbench/ebtp_props.sv ***
// checker of the timer block: apb answer, interrupt gating, watchdog pulse.
// assumes: bound onto ebtp_top, one clock, synchronous active-low reset.
`timescale 1ns/1ps
`include "ebtp_map.svh"
module ebtp_props (
    input wire logic        i_clk_sys,
    input wire logic        i_rstn,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_sleep,
    input wire logic        o_irq,
    input wire logic        o_wdt_timeout
);
    logic       en_q;
    logic       wm_q;
    logic       wd_q;
    logic [2:0] calm_q;
    logic       wr_ok;
    logic       unmapped;
    // *****
    // shadows
    // *****
    assign wr_ok = i_psel && i_penable && i_pwrite && o_pready;
    assign unmapped = i_paddr > `EBTP_OFF_WDOG;
    // enable and mask copies, software is their only writer
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            en_q <= 1'b0;
            wm_q <= 1'b0;
            wd_q <= 1'b0;
        end else if (wr_ok) begin
            if (i_paddr == `EBTP_OFF_INTCTL) begin
                en_q <= i_pwdata[`EBTP_INT_EN_BIT];
            end
            if (i_paddr == `EBTP_OFF_MASK) begin
                en_q <= i_pwdata[0];
                wm_q <= i_pwdata[1];
            end
            if (i_paddr == `EBTP_OFF_WDOG) begin
                wd_q <= i_pwdata[`EBTP_WD_EN_BIT];
            end
        end
    end
    // cycles of sleep without writes; four cover the flag-to-irq pipeline
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn || !i_sleep || wr_ok) begin
            calm_q <= 3'h0;
        end else if (calm_q != 3'h7) begin
            calm_q <= calm_q + 3'h1;
        end
    end
    // *****
    // properties
    // *****
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    AST_READY_WAIT: assert property (i_psel && $rose(i_penable) |-> !o_pready ##1 o_pready)
        else $error("ready not in second access cycle");
    AST_READY_PULSE: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    AST_IDLE_DATA: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer");
    AST_UNMAPPED: assert property (o_pready && unmapped |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped address not refused");
    AST_MAPPED: assert property (o_pready && !unmapped && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
        else $error("mapped address refused");
    AST_IRQ_GATED: assert property (!en_q && !wm_q |=> !o_irq)
        else $error("irq with both enables off");
    AST_SLEEP_QUIET: assert property (calm_q >= 3'h4 && !wm_q |-> !$rose(o_irq))
        else $error("timer irq rose during sleep");
    AST_WDT_PULSE: assert property (o_wdt_timeout |=> !o_wdt_timeout)
        else $error("watchdog pulse too long");
    AST_WDT_OFF: assert property (!wd_q && !$past(wd_q) |=> !o_wdt_timeout)
        else $error("watchdog pulse while disabled");
    AST_WDT_CLEARED: assert property (wr_ok && i_paddr == `EBTP_OFF_WDOG && i_pwdata[0]
        |-> ##3 !o_wdt_timeout [*8])
        else $error("watchdog wrapped right after clear");
    cover property (o_pready && o_pslverr);
    cover property ($rose(o_irq));
    cover property (o_wdt_timeout);
    cover property (calm_q == 3'h7);
endmodule : ebtp_props

bind ebtp_top ebtp_props u_props (.*);

// *** testbench/ebtp_pulse_src.sv ***
// external count pulse source driving the timer pin.
// assumes: started by the bench on its clock; pin idles low between bursts.
`timescale 1ns/1ps
module ebtp_pulse_src (
    input  wire logic       i_clk_sys,
    input  wire logic       i_go,
    input  wire logic [7:0] i_n,
    input  wire logic [3:0] i_half,
    output logic            o_pin,
    output logic            o_busy
);
    // each level held i_half clocks, never under six, else edges are lost
    initial begin
        o_pin = 1'b0;
        o_busy = 1'b0;
        forever begin
            @(posedge i_clk_sys);
            if (i_go === 1'b1) begin
                o_busy <= 1'b1;
                repeat (i_n) begin
                    o_pin <= 1'b1;
                    repeat (i_half) @(posedge i_clk_sys);
                    o_pin <= 1'b0;
                    repeat (i_half) @(posedge i_clk_sys);
                end
                o_busy <= 1'b0;
            end
        end
    end
endmodule : ebtp_pulse_src

// *** testbench/eight_bit_timer_prescaler_tb.sv ***
// self-checking bench of the eight-bit timer over apb and its count pin.
// assumes: ebtp_top, ebtp_props bound to it, ebtp_pulse_src on the pin.
`timescale 1ns/1ps
`include "ebtp_map.svh"
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
module eight_bit_timer_prescaler_tb;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, sleep, irq, wdt_to;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        go, busy, pin, er_w;
    logic [7:0]  src_n, pre, opt;
    logic [3:0]  half;
    logic [31:0] rd_w;
    integer      seed, failures, total_checks, i, n, ratio;

    always #5 clk = ~clk;

    ebtp_top dut (.i_clk_sys(clk), .i_rstn(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_sleep(sleep), .i_ext_count_input(pin), .o_irq(irq), .o_wdt_timeout(wdt_to));
    ebtp_pulse_src u_src (.i_clk_sys(clk), .i_go(go), .i_n(src_n), .i_half(half), .o_pin(pin), .o_busy(busy));

    // *****
    // tasks
    // *****
    task complete_run;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // one apb transfer; waits for pready, the hang guard bounds it
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_w = prdata;
        er_w = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // burst of pulses, slow or prompt by a random level length
    task pulses(input integer cnt);
        src_n <= 8'(cnt);
        half <= 4'h6 + 4'({$random(seed)} % 10);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        wait (busy !== 1'b1);
        repeat (14) @(posedge clk);
    endtask : pulses

    // counts sampled off a free-running phase may land one either side
    function logic [7:0] near(input logic [7:0] s, input logic [7:0] e);
        near = (s == e + 8'h01 || s == e - 8'h01) ? e : s;
    endfunction : near

    // *****
    // scenarios
    // *****
    initial begin
        seed = 67371;
        failures = 0;
        total_checks = 0;
        {clk, rst_n, psel, penable, pwrite, sleep, go} = 7'h00;
        {paddr, pwdata, src_n, half} = {8'h00, 32'h0, 8'h00, 4'h6};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(8'(4 * i));
            `CHK("reset_value", (i == 1) ? 32'h08 : 32'h0, (i == 0) ? {24'h0, near(rd_w[7:0], 8'h00)} : rd_w)
        end
        rd(8'h18);
        `CHK("unmapped_err", 1'b1, er_w)
        // every ratio, then undivided with the prescaler on the watchdog
        for (i = 0; i < 9; i++) begin
            opt = (i < 8) ? 8'(i) : 8'h08;
            ratio = (i < 8) ? (2 << i) : 1;
            apb(1'b1, `EBTP_OFF_OPTION, {24'h0, opt});
            apb(1'b1, `EBTP_OFF_COUNT, 32'h0);
            repeat (14 * ratio - 4) @(posedge clk);
            rd(`EBTP_OFF_COUNT);
            `CHK("count_rate", 8'h03, near(rd_w[7:0], 8'h03))
        end
        apb(1'b1, `EBTP_OFF_STATUS, 32'h3);
        pre = 8'hF0 + 8'({$random(seed)} % 12);
        apb(1'b1, `EBTP_OFF_COUNT, {24'h0, pre});
        repeat (4 * (256 - pre) + 12) @(posedge clk);
        `CHK("irq_masked", 1'b0, irq)
        rd(`EBTP_OFF_INTCTL);
        `CHK("flag_set", 32'h04, rd_w)
        repeat (40) @(posedge clk);
        rd(`EBTP_OFF_INTCTL);
        `CHK("flag_kept", 32'h04, rd_w)
        apb(1'b1, `EBTP_OFF_INTCTL, 32'h20);
        repeat (3) @(posedge clk);
        `CHK("irq_on", 1'b1, irq)
        apb(1'b1, `EBTP_OFF_INTCTL, 32'h24);
        repeat (3) @(posedge clk);
        `CHK("irq_off", 1'b0, irq)
        rd(`EBTP_OFF_INTCTL);
        `CHK("flag_cleared", 32'h20, rd_w)
        apb(1'b1, `EBTP_OFF_INTCTL, 32'h0);
        sleep <= 1'b1;
        repeat (2) @(posedge clk);
        rd(`EBTP_OFF_COUNT);
        pre = rd_w[7:0];
        repeat (100) @(posedge clk);
        rd(`EBTP_OFF_COUNT);
        `CHK("sleep_frozen", pre, rd_w[7:0])
        sleep <= 1'b0;
        // pin edges: rising, falling, rising through the 1:2 prescaler
        for (i = 0; i < 3; i++) begin
            opt = (i == 0) ? 8'h28 : ((i == 1) ? 8'h38 : 8'h20);
            apb(1'b1, `EBTP_OFF_OPTION, {24'h0, opt});
            repeat (12) @(posedge clk);
            apb(1'b1, `EBTP_OFF_COUNT, 32'h0);
            n = 2 + 2 * ({$random(seed)} % 8);
            pulses(n);
            rd(`EBTP_OFF_COUNT);
            `CHK("ext_count", 8'(n / ((i == 2) ? 2 : 1)), rd_w[7:0])
        end
        apb(1'b1, `EBTP_OFF_COUNT, 32'h0);
        pulses(1);
        apb(1'b1, `EBTP_OFF_COUNT, 32'h0);
        pulses(1);
        rd(`EBTP_OFF_COUNT);
        `CHK("presc_cleared", 8'h01, rd_w[7:0])
        apb(1'b1, `EBTP_OFF_OPTION, 32'h08);
        apb(1'b1, `EBTP_OFF_WDOG, 32'h02);
        repeat (100) @(posedge clk);
        apb(1'b1, `EBTP_OFF_WDOG, 32'h03);
        rd(`EBTP_OFF_WDOG);
        `CHK("wdt_cleared", 8'h00, near(rd_w[15:8], 8'h00))
        `CHK("wdt_clear_bit", 8'h02, rd_w[7:0])
        wait (wdt_to === 1'b1);
        rd(`EBTP_OFF_STATUS);
        `CHK("wdt_flag", 1'b1, rd_w[1])
        apb(1'b1, `EBTP_OFF_MASK, 32'h02);
        repeat (3) @(posedge clk);
        `CHK("wdt_irq", 1'b1, irq)
        apb(1'b1, `EBTP_OFF_WDOG, 32'h0);
        apb(1'b1, `EBTP_OFF_STATUS, 32'h2);
        repeat (3) @(posedge clk);
        `CHK("wdt_irq_clr", 1'b0, irq)
        complete_run();
    end

    // hang guard, well past the longest sequence above
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule : eight_bit_timer_prescaler_tb
